// [design/dct_pkg.sv]
// shared constants for the debug csr and trigger block
package dct_pkg;
   // csr addresses
   localparam logic [11:0] CSR_DBG_CTRL_STAT = 12'h07b0;
   localparam logic [11:0] CSR_DBG_RESUME_PC = 12'h07b1;
   localparam logic [11:0] CSR_DBG_SCRATCH0  = 12'h07b2;
   localparam logic [11:0] CSR_DBG_SCRATCH1  = 12'h07b3;
   localparam logic [11:0] CSR_TRIG_SELECT   = 12'h07a0;
   localparam logic [11:0] CSR_TRIG_DATA1    = 12'h07a1;
   localparam logic [11:0] CSR_TRIG_DATA2    = 12'h07a2;
   localparam logic [11:0] CSR_TRIG_CONTROL  = 12'h07a5;
   // debug control/status fields
   localparam logic [3:0]  DCS_VERSION       = 4'h4;
   localparam int          DCS_EBRKM_BIT     = 15;
   localparam int          DCS_EBRKU_BIT     = 12;
   localparam int          DCS_STEP_BIT      = 2;
   // entry reason codes
   localparam logic [2:0]  CAUSE_EBREAK      = 3'h1;
   localparam logic [2:0]  CAUSE_TRIGGER     = 3'h2;
   localparam logic [2:0]  CAUSE_HALTREQ     = 3'h3;
   localparam logic [2:0]  CAUSE_STEP        = 3'h4;
   // privilege levels
   localparam logic [1:0]  PRV_USER          = 2'h0;
   localparam logic [1:0]  PRV_MACHINE       = 2'h3;
   // trigger unit layout
   localparam int          NTRIG             = 2;
   localparam logic [2:0]  TSEL_MAX          = 3'h1;
   localparam logic [3:0]  TRIG_TYPE_MATCH   = 4'h2;
   localparam int          TD1_DMODE_BIT     = 27;
   localparam int          TD1_HIT_BIT       = 20;
   localparam int          TD1_ACTION_LSB    = 12;
   localparam int          TD1_MATCH_LSB     = 7;
   localparam int          TD1_M_BIT         = 6;
   localparam int          TD1_U_BIT         = 3;
   localparam int          TD1_EXEC_BIT      = 2;
   localparam int          TD1_STORE_BIT     = 1;
   localparam int          TD1_LOAD_BIT      = 0;
   localparam int          TCTL_MPTE_BIT     = 7;
   localparam int          TCTL_MTE_BIT      = 3;
   // trap cause for breakpoint exception
   localparam logic [4:0]  EXC_CAUSE_BKPT    = 5'h03;
   // program buffer and resume pc reset value
   localparam int          PB_WORDS          = 16;
   localparam logic [31:0] DPC_RESET         = 32'h0000_0000;

   // one trigger unit
   typedef struct packed {
      logic        dmode;
      logic        hit;
      logic        action;
      logic        napot;
      logic        m_en;
      logic        u_en;
      logic        exec_en;
      logic        store_en;
      logic        load_en;
      logic [31:0] addr;
   } dct_trig_s;
endpackage

// [design/dct_core_debug.sv]
// What this block does
// [RULE1] version field reads constant 4
// [RULE2] machine breakpoint enters debug when enabled
// [RULE3] user breakpoint enters debug when enabled
// [RULE4] stop bits read zero, ignore writes
// [RULE5] entry reason code records why entered
// [RULE6] highest priority reason wins same cycle
// [RULE7] step runs one instruction then halts
// [RULE8] faulting step halts before trap handler
// [RULE9] privilege captured on entry, restored on exit
// [RULE10] resume pc saved on entry, used on resume
// [RULE11] select maps data registers to unit
// [RULE12] oversize select clipped, readable back
// [RULE13] type field reads constant 2
// [RULE14] action writable only by debugger
// [RULE15] hit flag sticky until cleared
// [RULE16] match instruction or load/store addresses
// [RULE17] power-of-two region from trailing ones
// [RULE18] shared enable suppresses breakpoints in traps
// [RULE19] shared enable ignores debug-action triggers
// [RULE20] debug-action trigger halts and reports halted
// [RULE21] debugger halts core, accesses gprs
// [RULE22] sixteen word program buffer
// [RULE23] exception trigger saves pc, cause 3, hit
// [RULE24] debug action beats exception action
// [RULE25] trap pushes enable, return pops it
// [RULE26] reset: select zero, hits clear, exception action
`timescale 1ns/1ns
`default_nettype none
module dct_core_debug (
   // clock and reset
   input  wire  logic                      SYS_CLK,
   input  wire  logic                      SRST,
   // csr port from the core
   input  wire  logic                      CSR_RD,
   input  wire  logic                      CSR_WR,
   input  wire  logic [11:0]               CSR_ADDR,
   input  wire  logic [31:0]               CSR_WDATA,
   output logic [31:0]                     CSR_RDATA,
   output logic                            CSR_RVALID,
   // core execution status
   input  wire  logic [1:0]                CORE_PRIV,
   input  wire  logic                      DEC_VALID,
   input  wire  logic [31:0]               DEC_PC,
   input  wire  logic                      DEC_EBREAK,
   input  wire  logic                      LS_VALID,
   input  wire  logic                      LS_STORE,
   input  wire  logic [31:0]               LS_ADDR,
   input  wire  logic [1:0]                LS_SIZE,
   input  wire  logic                      INSTR_DONE,
   input  wire  logic                      INSTR_EXC,
   input  wire  logic [31:0]               STEP_NEXT_PC,
   input  wire  logic                      TRAP_TAKE,
   input  wire  logic                      MRET_EXEC,
   // debug mode control to the core
   output logic                            DEBUG_MODE,
   output logic                            DEBUG_ENTER,
   output logic                            RESUME,
   output logic [31:0]                     RESUME_PC,
   output logic [1:0]                      RESUME_PRIV,
   output logic                            TRIG_EXC,
   output logic [31:0]                     TRIG_EXC_EPC,
   output logic [4:0]                      TRIG_EXC_CAUSE,
   output logic [dct_pkg::NTRIG-1:0]       TRIG_EXC_HIT,
   // debug module requests, from outside the clock domain
   input  wire  logic                      DM_HALT_REQ,
   input  wire  logic                      DM_RESUME_REQ,
   output logic                            DM_HALTED,
   // abstract gpr access
   input  wire  logic                      ABS_REQ,
   input  wire  logic                      ABS_WRITE,
   input  wire  logic [4:0]                ABS_REGNO,
   input  wire  logic [31:0]               ABS_WDATA,
   output logic [31:0]                     ABS_RDATA,
   output logic                            ABS_DONE,
   output logic                            GPR_REQ,
   output logic                            GPR_WE,
   output logic [4:0]                      GPR_ADDR,
   output logic [31:0]                     GPR_WDATA,
   input  wire  logic [31:0]               GPR_RDATA,
   // program buffer
   input  wire  logic                      PB_WE,
   input  wire  logic [3:0]                PB_ADDR,
   input  wire  logic [31:0]               PB_WDATA,
   input  wire  logic [3:0]                PB_FETCH_ADDR,
   output logic [31:0]                     PB_FETCH_DATA
);
   import dct_pkg::*;

   // complete state of the block
   typedef struct packed {
      logic                       hreq_s1;     // halt request sync stage one
      logic                       hreq_s2;     // halt request sync stage two
      logic                       rreq_s1;     // resume request sync stage one
      logic                       rreq_s2;     // resume request sync stage two
      logic                       rreq_d;      // delayed copy for edge detect
      logic                       dbg_mode;    // core is halted in debug mode
      logic                       step_arm;    // one instruction may still run
      logic                       ebrk_m;      // machine breakpoint to debug
      logic                       ebrk_u;      // user breakpoint to debug
      logic                       step;        // single step enable
      logic [2:0]                 cause;       // last entry reason
      logic [1:0]                 prv;         // privilege for exit
      logic [31:0]                dpc;         // resume address
      logic [31:0]                scr0;        // scratch zero
      logic [31:0]                scr1;        // scratch one
      logic [2:0]                 tsel;        // selected trigger index
      dct_trig_s [NTRIG-1:0]      trig;        // trigger units
      logic                       mte;         // trigger enable
      logic                       mpte;        // trigger enable before trap
      logic [31:0]                rdata;       // csr read data
      logic                       rvalid;      // csr read answer
      logic                       enter_p;     // debug entry pulse
      logic                       resume_p;    // resume pulse
      logic                       texc_p;      // trigger exception pulse
      logic [31:0]                texc_epc;    // trigger exception return pc
      logic [NTRIG-1:0]           texc_hit;    // triggers behind the exception
      logic                       gpr_req;     // gpr access pulse
      logic                       gpr_we;      // gpr access is a write
      logic [4:0]                 gpr_addr;    // gpr number
      logic [31:0]                gpr_wdata;   // gpr write data
      logic                       abs_done;    // abstract command finished
      logic [31:0]                abs_rdata;   // abstract read result
      logic [PB_WORDS-1:0][31:0]  pb;          // program buffer words
      logic [31:0]                pb_rdata;    // fetched program buffer word
   } dct_state_s;

   dct_state_s st_r;   // registered state
   dct_state_s st_nxt; // next state

   // address match for one trigger against the byte span lo..hi
   function automatic logic trig_match(input dct_trig_s t, input logic [31:0] lo,
                                       input logic [31:0] hi);
      logic [31:0] care;
      care = ~(t.addr ^ (t.addr + 32'h0000_0001)); // trailing ones and next zero dropped
      if (t.napot) begin
         // aligned region; the access counts if its first or last byte is inside it
         trig_match = ((lo & care) == (t.addr & care)) || ((hi & care) == (t.addr & care)); // [RULE17]
      end else begin
         trig_match = (t.addr >= lo) && (t.addr <= hi);
      end
   endfunction

   // read view of one trigger as its first data register
   function automatic logic [31:0] trig_data1(input dct_trig_s t);
      trig_data1 = {TRIG_TYPE_MATCH, t.dmode, 6'h00, t.hit, 4'h0, 3'h0, t.action, 1'b0,
                    3'h0, t.napot, t.m_en, 2'h0, t.u_en, t.exec_en, t.store_en,
                    t.load_en}; // [RULE13]
   endfunction

   // combinational signals
   logic [31:0]       ls_hi;      // last byte of the load/store
   logic [NTRIG-1:0]  fire;       // triggers matching this cycle
   logic              fire_dbg;   // any firing trigger wants debug
   logic              fire_exc;   // any firing trigger wants an exception
   logic              ebrk_dbg;   // breakpoint instruction goes to debug
   logic              step_end;   // stepped instruction finished
   logic              hreq;       // synchronised halt request
   logic              rreq_rise;  // resume request edge
   logic              priv_ok;    // trigger enabled for current privilege
   logic [0:0]        sel;        // clipped index into the trigger array
   logic              twr_ok;     // selected trigger may be written

   // next state
   always_comb begin
      st_nxt = st_r;
      ls_hi  = LS_ADDR + ((32'h0000_0001 << LS_SIZE) - 32'h0000_0001);
      hreq   = st_r.hreq_s2;
      rreq_rise = st_r.rreq_s2 & ~st_r.rreq_d;
      sel    = st_r.tsel[0:0];
      twr_ok = ~st_r.trig[sel].dmode | st_r.dbg_mode;

      // requests from the debug module's domain pass two flops first
      st_nxt.hreq_s1 = DM_HALT_REQ;
      st_nxt.hreq_s2 = st_r.hreq_s1;
      st_nxt.rreq_s1 = DM_RESUME_REQ;
      st_nxt.rreq_s2 = st_r.rreq_s1;
      st_nxt.rreq_d  = st_r.rreq_s2;

      // pulses default low
      st_nxt.enter_p  = 1'b0;
      st_nxt.resume_p = 1'b0;
      st_nxt.texc_p   = 1'b0;
      st_nxt.rvalid   = 1'b0;
      st_nxt.gpr_req  = 1'b0;
      st_nxt.abs_done = 1'b0;

      // trigger evaluation, never while halted
      fire = '0;
      for (int i = 0; i < NTRIG; i++) begin
         priv_ok = (CORE_PRIV == PRV_MACHINE) ? st_r.trig[i].m_en : st_r.trig[i].u_en;
         if (!st_r.dbg_mode && priv_ok) begin
            // only addresses are compared, never data
            fire[i] = (st_r.trig[i].exec_en && DEC_VALID &&
                       trig_match(st_r.trig[i], DEC_PC, DEC_PC)) ||
                      (st_r.trig[i].load_en && LS_VALID && !LS_STORE &&
                       trig_match(st_r.trig[i], LS_ADDR, ls_hi)) ||
                      (st_r.trig[i].store_en && LS_VALID && LS_STORE &&
                       trig_match(st_r.trig[i], LS_ADDR, ls_hi)); // [RULE16]
            // exception-action triggers are held off by the shared enable
            if (!st_r.trig[i].action && !st_r.mte) begin
               fire[i] = 1'b0; // [RULE18]
            end
         end
      end
      fire_dbg = 1'b0;
      fire_exc = 1'b0;
      for (int i = 0; i < NTRIG; i++) begin
         fire_dbg = fire_dbg | (fire[i] & st_r.trig[i].action); // [RULE19]
         fire_exc = fire_exc | (fire[i] & ~st_r.trig[i].action);
      end

      ebrk_dbg = DEC_VALID && DEC_EBREAK && !st_r.dbg_mode &&
                 ((CORE_PRIV == PRV_MACHINE && st_r.ebrk_m) ||
                  (CORE_PRIV == PRV_USER && st_r.ebrk_u)); // [RULE2] [RULE3]
      step_end = st_r.step_arm && (INSTR_DONE || INSTR_EXC); // [RULE7] [RULE8]

      // csr writes come first so hardware events below win over them
      if (CSR_WR) begin
         case (CSR_ADDR)
            CSR_DBG_CTRL_STAT: begin
               if (st_r.dbg_mode) begin
                  st_nxt.ebrk_m = CSR_WDATA[DCS_EBRKM_BIT];
                  st_nxt.ebrk_u = CSR_WDATA[DCS_EBRKU_BIT];
                  st_nxt.step   = CSR_WDATA[DCS_STEP_BIT];
                  // unsupported levels leave the field unchanged
                  if (CSR_WDATA[1:0] == PRV_MACHINE || CSR_WDATA[1:0] == PRV_USER) begin
                     st_nxt.prv = CSR_WDATA[1:0]; // [RULE9]
                  end
               end
            end
            CSR_DBG_RESUME_PC: begin
               if (st_r.dbg_mode) begin
                  st_nxt.dpc = CSR_WDATA; // [RULE10]
               end
            end
            CSR_DBG_SCRATCH0: begin
               if (st_r.dbg_mode) begin
                  st_nxt.scr0 = CSR_WDATA;
               end
            end
            CSR_DBG_SCRATCH1: begin
               if (st_r.dbg_mode) begin
                  st_nxt.scr1 = CSR_WDATA;
               end
            end
            CSR_TRIG_SELECT: begin
               // software counts triggers by writing all ones and reading back
               st_nxt.tsel = (CSR_WDATA > 32'(TSEL_MAX)) ? TSEL_MAX : CSR_WDATA[2:0]; // [RULE12]
            end
            CSR_TRIG_DATA1: begin
               if (twr_ok) begin
                  st_nxt.trig[sel].hit      = CSR_WDATA[TD1_HIT_BIT]; // [RULE11]
                  st_nxt.trig[sel].napot    = |CSR_WDATA[TD1_MATCH_LSB +: 4];
                  st_nxt.trig[sel].m_en     = CSR_WDATA[TD1_M_BIT];
                  st_nxt.trig[sel].u_en     = CSR_WDATA[TD1_U_BIT];
                  st_nxt.trig[sel].exec_en  = CSR_WDATA[TD1_EXEC_BIT];
                  st_nxt.trig[sel].store_en = CSR_WDATA[TD1_STORE_BIT];
                  st_nxt.trig[sel].load_en  = CSR_WDATA[TD1_LOAD_BIT];
                  // only the debugger owns dmode and the debug action
                  if (st_r.dbg_mode) begin
                     st_nxt.trig[sel].dmode  = CSR_WDATA[TD1_DMODE_BIT];
                     st_nxt.trig[sel].action = (CSR_WDATA[TD1_ACTION_LSB +: 4] == 4'h1) &&
                                               CSR_WDATA[TD1_DMODE_BIT]; // [RULE14]
                  end
               end
            end
            CSR_TRIG_DATA2: begin
               if (twr_ok) begin
                  st_nxt.trig[sel].addr = CSR_WDATA; // [RULE11]
               end
            end
            CSR_TRIG_CONTROL: begin
               st_nxt.mte  = CSR_WDATA[TCTL_MTE_BIT];
               st_nxt.mpte = CSR_WDATA[TCTL_MPTE_BIT];
            end
            default: begin
               // other csrs belong to the core
            end
         endcase
      end

      // csr read, answered one cycle later
      if (CSR_RD) begin
         st_nxt.rvalid = 1'b1;
         case (CSR_ADDR)
            CSR_DBG_CTRL_STAT: st_nxt.rdata = {DCS_VERSION, 12'h000, st_r.ebrk_m, 2'h0,
                                               st_r.ebrk_u, 1'b0, 1'b0, 1'b0, st_r.cause,
                                               3'h0, st_r.step, st_r.prv}; // [RULE1] [RULE4]
            CSR_DBG_RESUME_PC: st_nxt.rdata = st_r.dpc;
            CSR_DBG_SCRATCH0:  st_nxt.rdata = st_r.scr0;
            CSR_DBG_SCRATCH1:  st_nxt.rdata = st_r.scr1;
            CSR_TRIG_SELECT:   st_nxt.rdata = {29'h0000_0000, st_r.tsel};
            CSR_TRIG_DATA1:    st_nxt.rdata = trig_data1(st_r.trig[sel]); // [RULE11]
            CSR_TRIG_DATA2:    st_nxt.rdata = st_r.trig[sel].addr;
            CSR_TRIG_CONTROL:  st_nxt.rdata = {24'h00_0000, st_r.mpte, 3'h0, st_r.mte, 3'h0};
            default:           st_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // hit flags set on firing; set beats a clear in the same cycle
      for (int i = 0; i < NTRIG; i++) begin
         if (fire[i]) begin
            st_nxt.trig[i].hit = 1'b1; // [RULE15]
         end
      end

      // enable push on any machine trap, pop on return from trap
      if (MRET_EXEC) begin
         st_nxt.mte  = st_r.mpte; // [RULE25]
         st_nxt.mpte = 1'b0;
      end
      if (TRAP_TAKE || (fire_exc && !(fire_dbg || ebrk_dbg || hreq || step_end))) begin
         st_nxt.mpte = st_r.mte; // [RULE25]
         st_nxt.mte  = 1'b0;
      end

      // debug entry, highest priority reason recorded
      if (!st_r.dbg_mode) begin
         if (fire_dbg) begin
            st_nxt.cause = CAUSE_TRIGGER; // [RULE6] [RULE20] [RULE24]
            st_nxt.dpc   = DEC_PC;
         end else if (ebrk_dbg) begin
            st_nxt.cause = CAUSE_EBREAK; // [RULE6]
            st_nxt.dpc   = DEC_PC;
         end else if (hreq) begin
            st_nxt.cause = CAUSE_HALTREQ; // [RULE6] [RULE21]
            st_nxt.dpc   = DEC_PC;
         end else if (step_end) begin
            // a faulting step already points at the handler
            st_nxt.cause = CAUSE_STEP; // [RULE6] [RULE8]
            st_nxt.dpc   = STEP_NEXT_PC;
         end
         if (fire_dbg || ebrk_dbg || hreq || step_end) begin
            st_nxt.dbg_mode = 1'b1; // [RULE5] [RULE10]
            st_nxt.enter_p  = 1'b1;
            st_nxt.step_arm = 1'b0;
            st_nxt.prv      = CORE_PRIV; // [RULE9]
         end else if (fire_exc) begin
            // breakpoint exception with the decode address as return
            st_nxt.texc_p   = 1'b1; // [RULE23]
            st_nxt.texc_epc = DEC_PC;
            st_nxt.texc_hit = fire;
         end
      end else if (rreq_rise) begin
         st_nxt.dbg_mode = 1'b0; // [RULE10] [RULE9]
         st_nxt.resume_p = 1'b1;
         st_nxt.step_arm = st_r.step; // [RULE7]
      end

      // abstract gpr access only while halted
      if (ABS_REQ && st_r.dbg_mode) begin
         st_nxt.gpr_req   = 1'b1; // [RULE21]
         st_nxt.gpr_we    = ABS_WRITE;
         st_nxt.gpr_addr  = ABS_REGNO;
         st_nxt.gpr_wdata = ABS_WDATA;
      end
      if (st_r.gpr_req) begin
         st_nxt.abs_done  = 1'b1;
         st_nxt.abs_rdata = st_r.gpr_we ? st_r.abs_rdata : GPR_RDATA;
      end

      // program buffer write and core fetch
      if (PB_WE) begin
         st_nxt.pb[PB_ADDR] = PB_WDATA; // [RULE22]
      end
      st_nxt.pb_rdata = st_r.pb[PB_FETCH_ADDR];

      // reset: select zero, no hits, exception action
      if (SRST) begin
         st_nxt          = '0; // [RULE26]
         st_nxt.prv      = PRV_MACHINE;
         st_nxt.dpc      = DPC_RESET;
         st_nxt.mte      = 1'b0;
      end
   end

   // state register
   always_ff @(posedge SYS_CLK) begin
      st_r <= st_nxt;
   end

   // outputs straight from state, except the constant exception cause
   assign CSR_RDATA      = st_r.rdata;
   assign CSR_RVALID     = st_r.rvalid;
   assign DEBUG_MODE     = st_r.dbg_mode;
   assign DM_HALTED      = st_r.dbg_mode; // [RULE20]
   assign DEBUG_ENTER    = st_r.enter_p;
   assign RESUME         = st_r.resume_p;
   assign RESUME_PC      = st_r.dpc; // [RULE10]
   assign RESUME_PRIV    = st_r.prv; // [RULE9]
   assign TRIG_EXC       = st_r.texc_p;
   assign TRIG_EXC_EPC   = st_r.texc_epc;
   assign TRIG_EXC_CAUSE = EXC_CAUSE_BKPT; // [RULE23]
   assign TRIG_EXC_HIT   = st_r.texc_hit;
   assign GPR_REQ        = st_r.gpr_req;
   assign GPR_WE         = st_r.gpr_we;
   assign GPR_ADDR       = st_r.gpr_addr;
   assign GPR_WDATA      = st_r.gpr_wdata;
   assign ABS_RDATA      = st_r.abs_rdata;
   assign ABS_DONE       = st_r.abs_done;
   assign PB_FETCH_DATA  = st_r.pb_rdata;
endmodule
`default_nettype wire

// [verification/dct_core_debug_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// port-level watch on debug entry, resume, trigger exceptions and csr timing
module dct_core_debug_chk (
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        SRST,
   // watched ports
   input wire logic        CSR_RD,
   input wire logic        CSR_RVALID,
   input wire logic        DEBUG_MODE,
   input wire logic        DEBUG_ENTER,
   input wire logic        RESUME,
   input wire logic        TRIG_EXC,
   input wire logic [4:0]  TRIG_EXC_CAUSE,
   input wire logic [1:0]  TRIG_EXC_HIT,
   input wire logic        ABS_REQ,
   input wire logic        GPR_REQ,
   input wire logic        ABS_DONE
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   a_read_answer: assert property (CSR_RD |=> CSR_RVALID)
      else $error("read unanswered");
   a_enter_mode: assert property (DEBUG_ENTER |-> DEBUG_MODE && !$past(DEBUG_MODE))
      else $error("entry without mode");
   a_no_reentry: assert property (DEBUG_MODE |=> !DEBUG_ENTER)
      else $error("entry while halted");
   a_resume_exit: assert property (RESUME |-> !DEBUG_MODE && $past(DEBUG_MODE))
      else $error("resume without exit");
   a_mode_holds: assert property ($fell(DEBUG_MODE) |-> RESUME)
      else $error("mode dropped");
   a_exc_cause: assert property (TRIG_EXC |-> TRIG_EXC_CAUSE == 5'h03 &&
      TRIG_EXC_HIT != 2'h0) else $error("bad exception cause");
   a_exc_halted: assert property (TRIG_EXC |-> !$past(DEBUG_MODE))
      else $error("exc while halted");
   a_abs_two: assert property (ABS_REQ && DEBUG_MODE |=> GPR_REQ ##1 ABS_DONE)
      else $error("abstract access late");
   // main scenarios reached
   c_enter: cover property (DEBUG_ENTER);
   c_resume: cover property (RESUME);
   c_exc: cover property (TRIG_EXC);
endmodule
bind dct_core_debug dct_core_debug_chk dct_core_debug_chk_inst (.*);
`default_nettype wire

// [verification/dct_dbg_model.sv]
`timescale 1ns/1ns
`default_nettype none
// debugger side: halt and resume requests move only on its own link clock
module dct_dbg_model (
   // link clock and bench commands
   input  wire logic link_clk,
   input  wire logic halt_cmd,
   input  wire logic resume_cmd,
   // request pins toward the core
   output var  logic halt_req,
   output var  logic resume_req
);
   // released at start so the core sees no request out of reset
   initial begin
      halt_req = 1'b0;
      resume_req = 1'b0;
   end
   // edges land on falling edges of the core clock; the core still synchronises them
   always @(posedge link_clk) begin
      halt_req <= halt_cmd;
      resume_req <= resume_cmd;
   end
endmodule
`default_nettype wire

// [verification/dct_core_debug_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// csr port, decode slot and debugger model driven, answers checked
module dct_core_debug_tb;
   import dct_pkg::*;
   // design inputs, link clock and several design outputs
   logic SYS_CLK = '0, SRST = '1, CSR_RD = '0, CSR_WR = '0, DEC_VALID = '0, DEC_EBREAK = '0;
   logic LS_VALID = '0, LS_STORE = '0, INSTR_DONE = '0, INSTR_EXC = '0, TRAP_TAKE = '0;
   logic MRET_EXEC = '0, ABS_REQ = '0, ABS_WRITE = '0, PB_WE = '0, link_clk = '0;
   logic [1:0] CORE_PRIV = PRV_MACHINE, LS_SIZE = '0, RESUME_PRIV;
   logic [3:0] PB_ADDR = '0, PB_FETCH_ADDR = '0;
   logic [4:0] ABS_REGNO = '0, TRIG_EXC_CAUSE, GPR_ADDR;
   logic [11:0] CSR_ADDR = '0;
   logic [31:0] CSR_WDATA = '0, DEC_PC = '0, LS_ADDR = '0, STEP_NEXT_PC = '0, ABS_WDATA = '0;
   logic [31:0] GPR_RDATA = '0, PB_WDATA = '0, CSR_RDATA, RESUME_PC, TRIG_EXC_EPC;
   logic [31:0] ABS_RDATA, GPR_WDATA, PB_FETCH_DATA;
   // design outputs and model pins
   logic CSR_RVALID, DEBUG_MODE, DEBUG_ENTER, RESUME, TRIG_EXC, DM_HALTED, ABS_DONE, GPR_REQ;
   logic GPR_WE, DM_HALT_REQ, DM_RESUME_REQ, halt_cmd = '0, resume_cmd = '0;
   logic [NTRIG-1:0] TRIG_EXC_HIT;
   int err_total = 0;
   int n_compared = 0;
   dct_core_debug dct_core_debug_inst (.*);
   dct_dbg_model dct_dbg_model_inst (.link_clk(link_clk), .halt_cmd(halt_cmd),
      .resume_cmd(resume_cmd), .halt_req(DM_HALT_REQ), .resume_req(DM_RESUME_REQ));
   always #4 SYS_CLK = ~SYS_CLK;
   always #80 link_clk = ~link_clk;
   // inputs change 1 ns after the edge, never on it
   task automatic step;
      @(posedge SYS_CLK);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      CSR_WR = 1'b1;
      CSR_ADDR = a;
      CSR_WDATA = d;
      step;
      CSR_WR = 1'b0;
      step;
   endtask
   // read answer is checked 1 ns after the edge that takes the read
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      CSR_RD = 1'b1;
      CSR_ADDR = a;
      step;
      CSR_RD = 1'b0;
      chk((CSR_RVALID === 1'b1) ? (CSR_RDATA & m) : 32'hdead_beef, e);
      step;
   endtask
   // halt (h=1) or resume (h=0), then wait for both pins to fall
   task automatic set_req(input logic h);
      halt_cmd = h;
      resume_cmd = !h;
      for (int i = 0; i < 200 && DEBUG_MODE !== h; i++) step;
      if (DEBUG_MODE !== h) begin
         err_total++;
         $display("ERROR %0t debug mode wait ran out", $time);
         give_verdict;
      end
      halt_cmd = 1'b0;
      resume_cmd = 1'b0;
      for (int i = 0; i < 99 && (DM_HALT_REQ | DM_RESUME_REQ) !== 1'b0; i++) step;
   endtask
   task automatic fire(input logic [31:0] pc);
      DEC_VALID = 1'b1;
      DEC_PC = pc;
      step;
      DEC_VALID = 1'b0;
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge SYS_CLK);
      #1;
      SRST = 1'b0;
      step;
      rd(CSR_TRIG_SELECT, '1, '0);
      rd(CSR_TRIG_DATA1, 32'hf010_1000, 32'h2000_0000);
      wr(CSR_TRIG_SELECT, 32'h0000_0007);
      rd(CSR_TRIG_SELECT, '1, 32'h0000_0001);
      wr(CSR_DBG_RESUME_PC, 32'h0000_0100);
      rd(CSR_DBG_RESUME_PC, '1, '0);
      $display("reset and select test done");
      set_req(1'b1);
      rd(CSR_DBG_CTRL_STAT, 32'hf000_01c3, 32'h4000_00c3);
      wr(CSR_DBG_CTRL_STAT, 32'h0000_0603);
      rd(CSR_DBG_CTRL_STAT, 32'h0000_0600, '0);
      ABS_REQ = 1'b1;
      step;
      ABS_REQ = 1'b0;
      step;
      chk(32'(ABS_DONE), 32'h0000_0001);
      wr(CSR_TRIG_DATA1, 32'h0000_00c4);
      wr(CSR_TRIG_DATA2, 32'h0000_0203);
      wr(CSR_TRIG_SELECT, '0);
      wr(CSR_TRIG_DATA1, 32'h0800_1044);
      wr(CSR_TRIG_DATA2, 32'h0000_0300);
      wr(CSR_TRIG_CONTROL, 32'h0000_0008);
      wr(CSR_DBG_RESUME_PC, 32'h0000_0100);
      set_req(1'b0);
      chk(RESUME_PC, 32'h0000_0100);
      $display("halt and resume test done");
      fire(32'h0000_0300);
      chk(32'(DEBUG_ENTER), 32'h0000_0001);
      rd(CSR_DBG_CTRL_STAT, 32'h0000_01c0, 32'h0000_0080);
      rd(CSR_DBG_RESUME_PC, '1, 32'h0000_0300);
      rd(CSR_TRIG_DATA1, 32'hf810_1000, 32'h2810_1000);
      set_req(1'b0);
      fire(32'h0000_0204);
      chk(32'(TRIG_EXC), 32'h0000_0001);
      chk(TRIG_EXC_EPC, 32'h0000_0204);
      chk(32'(TRIG_EXC_HIT), 32'h0000_0002);
      rd(CSR_TRIG_CONTROL, 32'h0000_0088, 32'h0000_0080);
      fire(32'h0000_0206);
      chk(32'(TRIG_EXC), '0);
      $display("trigger test done");
      give_verdict;
   end
endmodule
`default_nettype wire
